// ==== logic/scr_pkg.sv ====
// Constants, types and decode helpers for the supervisor control register.
// Assumes a 10 MHz ref_clk and a two-wire bus sampled from pins.
package scr_pkg;

  // Register address and data patterns
  localparam logic [15:0] REG_ADDR = 16'hffff;
  localparam logic [7:0] SET_WL = 8'h02;
  localparam logic [7:0] SET_BOTH = 8'h06;
  localparam logic [7:0] CLR_ALL = 8'h00;
  localparam logic [7:0] TRIP_DATA = 8'h00;

  // Register bit positions, bit 7 down to bit 0
  localparam int BIT_ARM = 7;
  localparam int BIT_WD_HI = 6;
  localparam int BIT_WD_LO = 5;
  localparam int BIT_SEL_1 = 4;
  localparam int BIT_SEL_0 = 3;
  localparam int BIT_REGISTER_WRITE_LATCH = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_SEL_2 = 0;

  // Bus framing counts, then address, page and counter widths
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 6;
  localparam int CNT_W = 24;

  // Slave address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2b;

  // Timing in its own units, then in clock cycles
  localparam int CLK_KHZ = 10000;
  localparam int DOG_LONG_MS = 1400;
  localparam int DOG_MID_MS = 600;
  localparam int DOG_SHORT_MS = 200;
  localparam int NV_CYCLE_MS = 10;
  localparam int DOG_LONG_CYC = DOG_LONG_MS * CLK_KHZ;
  localparam int DOG_MID_CYC = DOG_MID_MS * CLK_KHZ;
  localparam int DOG_SHORT_CYC = DOG_SHORT_MS * CLK_KHZ;
  localparam int NV_CYCLE_CYC = NV_CYCLE_MS * CLK_KHZ;

  // Watchdog period codes and lock codes
  localparam logic [1:0] DOG_LONG = 2'h0;
  localparam logic [1:0] DOG_MID = 2'h1;
  localparam logic [1:0] DOG_SHORT = 2'h2;
  localparam logic [1:0] DOG_OFF = 2'h3;
  localparam logic [2:0] LOCK_ALL = 3'h3;
  localparam logic [2:0] LOCK_NONE = 3'h0;

  // Pin slots in the synchroniser bank
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_PROT = 2;
  localparam int PIN_PV = 3;
  localparam int PIN_N = 4;
  // Idle pin levels for sync reset: bus lines high, others low
  localparam logic [PIN_N-1:0] PIN_IDLE = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_AHI = 3'h2,
    ST_ALO = 3'h3,
    ST_WR = 3'h4,
    ST_RD = 3'h5,
    ST_IGN = 3'h6
  } scr_state_type;

  // Nonvolatile fields of the control register
  typedef struct packed {
    logic arm;
    logic [1:0] period;
    logic [2:0] lock;
  } scr_nv_type;

  localparam scr_nv_type NV_FACTORY = '{arm: 1'b0, period: DOG_OFF,
                                        lock: LOCK_NONE};

  // One array write handed to the memory path
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } scr_wr_type;

  // Block lock decode: whole array, or first 1/2/4/8 pages
  function automatic logic prot_hit(input logic [2:0] lock,
                                    input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-PAGE_W-1:0] page;
    page = addr[ADDR_W-1:PAGE_W];
    if (lock == LOCK_ALL) begin
      prot_hit = 1'b1;
    end else if (lock[2]) begin
      prot_hit = ((page >> lock[1:0]) == '0);
    end else begin
      prot_hit = 1'b0;
    end
  endfunction

endpackage

// ==== logic/scr_nv_store.sv ====
// Nonvolatile store for the control register fields.
// Assumes the caller writes only on a completed nonvolatile update.
`timescale 1ns/100ps
module scr_nv_store
  import scr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire scr_nv_type wr_data,
  output scr_nv_type rd_q
);

  // Cells ignore logic reset and start at factory values
  scr_nv_type cell_q = NV_FACTORY;
  scr_nv_type cell_d;
  scr_nv_type rd_d;

  // Next cell content and registered read
  always_comb begin
    cell_d = wr_en ? wr_data : cell_q;
    rd_d = cell_q;
  end

  // Storage survives srst, like cells across power loss
  always_ff @(posedge ref_clk) begin
    cell_q <= cell_d;
    rd_q <= rd_d;
  end

endmodule // scr_nv_store

// ==== logic/scr_control_regs.sv ====
// Control register, write latches, block lock and watchdog of the
// supervisor, reached over the two-wire pins by an external master.
// Assumes SCL well below ref_clk/8 and an array memory outside.
`timescale 1ns/100ps
module scr_control_regs
  import scr_pkg::*;
#(
  parameter int DOG_LONG_CYC_P = DOG_LONG_CYC,
  parameter int DOG_MID_CYC_P = DOG_MID_CYC,
  parameter int DOG_SHORT_CYC_P = DOG_SHORT_CYC,
  parameter int NV_CYCLE_CYC_P = NV_CYCLE_CYC
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic protect_pin,
  input wire logic program_voltage,
  input wire logic [7:0] array_rd_data,
  output logic [ADDR_W-1:0] array_rd_addr,
  output logic array_wr_valid,
  output scr_wr_type array_wr,
  output logic [2:0] array_lock_sel,
  output logic [1:0] dog_period,
  output logic hw_protect,
  output logic dog_reset,
  output logic supply_trip_level,
  output logic nv_busy
);

  // Synchroniser bank for the pins
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;

  // Bus engine state
  scr_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, wdata_q, wdata_d;
  logic ack_q, ack_d, oe_q, oe_d, mnack_q, mnack_d;
  logic sent_q, sent_d, reg_rd_q, reg_rd_d;
  logic [1:0] nbyte_q, nbyte_d;
  logic [15:0] addr_q, addr_d;
  logic wel_q, wel_d, register_write_latch_q, register_write_latch_d;
  logic [CNT_W-1:0] busy_q, busy_d;
  logic trip_q, trip_d, awr_v_q, awr_v_d;
  scr_wr_type awr_q, awr_d;
  logic hwp_q, hwp_d, sda_out_q;
  logic nv_we;
  scr_nv_type nv_q, nv_new;

  // Watchdog state
  logic [CNT_W-1:0] dog_cnt_q, dog_cnt_d, dog_lim;
  logic dog_rst_q, dog_rst_d;

  // Pin events
  logic scl_f, sda_f, prot_f, pv_f;
  logic scl_rise, scl_fall, start_ev, stop_ev, is_reg;
  logic [7:0] reg_view, next_byte;

  assign pin_raw = {program_voltage, protect_pin, sda_in, scl_in};

  // Three-stage sync; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_comb begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
      end
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_q[gi] <= PIN_IDLE[gi];
          s2_q[gi] <= PIN_IDLE[gi];
          s3_q[gi] <= PIN_IDLE[gi];
          filt_q[gi] <= PIN_IDLE[gi];
          prev_q[gi] <= PIN_IDLE[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          filt_q[gi] <= filt_d[gi];
          prev_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  // Filtered levels and bus conditions
  assign scl_f = filt_q[PIN_SCL];
  assign sda_f = filt_q[PIN_SDA];
  assign prot_f = filt_q[PIN_PROT];
  assign pv_f = filt_q[PIN_PV];
  assign scl_rise = scl_f & ~prev_q[PIN_SCL];
  assign scl_fall = ~scl_f & prev_q[PIN_SCL];
  assign start_ev = scl_f & prev_q[PIN_SCL] & prev_q[PIN_SDA] & ~sda_f;
  assign stop_ev = scl_f & prev_q[PIN_SCL] & ~prev_q[PIN_SDA] & sda_f;
  assign is_reg = (addr_q == REG_ADDR);

  // Register image as read by the master
  always_comb begin
    reg_view = 8'h00;
    reg_view[BIT_ARM] = nv_q.arm;
    reg_view[BIT_WD_HI] = nv_q.period[1];
    reg_view[BIT_WD_LO] = nv_q.period[0];
    reg_view[BIT_SEL_1] = nv_q.lock[1];
    reg_view[BIT_SEL_0] = nv_q.lock[0];
    reg_view[BIT_REGISTER_WRITE_LATCH] = register_write_latch_q;
    reg_view[BIT_WEL] = wel_q;
    reg_view[BIT_SEL_2] = nv_q.lock[2];
    next_byte = reg_rd_q ? reg_view : array_rd_data;
  end

  // Nonvolatile fields
  scr_nv_store u_nv (
    .ref_clk(ref_clk),
    .wr_en(nv_we),
    .wr_data(nv_new),
    .rd_q(nv_q)
  );

  // Bus engine, write latches and store control
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    wdata_d = wdata_q;
    ack_d = ack_q;
    oe_d = oe_q;
    mnack_d = mnack_q;
    sent_d = sent_q;
    reg_rd_d = reg_rd_q;
    nbyte_d = nbyte_q;
    addr_d = addr_q;
    wel_d = wel_q;
    register_write_latch_d = register_write_latch_q;
    trip_d = trip_q;
    awr_v_d = 1'b0;
    awr_d = awr_q;
    nv_we = 1'b0;
    nv_new = nv_q;
    hwp_d = prot_f & nv_q.arm;
    busy_d = (busy_q != '0) ? busy_q - CNT_W'(1) : busy_q;
    if (trip_q && !pv_f) begin
      trip_d = 1'b0;
    end
    if (start_ev) begin
      st_d = ST_DEV;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_ev) begin
      // Stop commits the write after exactly one accepted register byte, or after one or more accepted array bytes
      if (st_q == ST_WR && nbyte_q == 2'h1) begin
        if (is_reg) begin
          if (!wel_q) begin
            wel_d = 1'b1;
          end else if (wdata_q == CLR_ALL) begin
            wel_d = 1'b0;
          end else if (!register_write_latch_q) begin
            if (wdata_q == SET_BOTH) begin
              register_write_latch_d = 1'b1;
            end
          end else if (wdata_q[BIT_WEL] && !wdata_q[BIT_REGISTER_WRITE_LATCH]) begin
            nv_we = 1'b1;
            nv_new.period = wdata_q[BIT_WD_HI:BIT_WD_LO];
            if (!hwp_q) begin
              nv_new.arm = wdata_q[BIT_ARM];
              nv_new.lock = {wdata_q[BIT_SEL_2],
                             wdata_q[BIT_SEL_1:BIT_SEL_0]};
            end
            register_write_latch_d = 1'b0;
            busy_d = CNT_W'(NV_CYCLE_CYC_P);
          end
        end else begin
          busy_d = CNT_W'(NV_CYCLE_CYC_P);
          if (pv_f && wdata_q == TRIP_DATA) begin
            trip_d = 1'b1;
          end
        end
      end
      st_d = ST_IDLE;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      // Sample on SCL rise
      if (scl_rise) begin
        if (ack_q) begin
          mnack_d = sda_f;
          cnt_d = ACK_SLOT;
        end else if (cnt_q < BIT_LAST) begin
          sh_d = {sh_q[6:0], sda_f};
          cnt_d = cnt_q + 4'h1;
        end
      end
      // Drive on SCL fall
      if (scl_fall) begin
        if (!ack_q && cnt_q == BIT_LAST) begin
          ack_d = 1'b1;
          oe_d = 1'b0;
          case (st_q)
            ST_DEV: begin
              if (sh_q[7:1] == DEV_ADDR && busy_q == '0) begin
                oe_d = 1'b1;
                if (sh_q[0]) begin
                  st_d = ST_RD;
                  reg_rd_d = is_reg;
                  sent_d = 1'b0;
                end else begin
                  st_d = ST_AHI;
                end
              end else begin
                st_d = ST_IGN;
              end
            end
            ST_AHI: begin
              addr_d[15:8] = sh_q;
              oe_d = 1'b1;
              st_d = ST_ALO;
            end
            ST_ALO: begin
              addr_d[7:0] = sh_q;
              oe_d = 1'b1;
              nbyte_d = 2'h0;
              st_d = ST_WR;
            end
            ST_WR: begin
              if (is_reg) begin
                if (nbyte_q == 2'h0 && (wel_q || sh_q == SET_WL)) begin
                  oe_d = 1'b1;
                  wdata_d = sh_q;
                  nbyte_d = 2'h1;
                end else begin
                  nbyte_d = 2'h2;
                end
              end else if (!wel_q) begin
                nbyte_d = 2'h2;
              end else if (prot_hit(nv_q.lock, addr_q[ADDR_W-1:0])) begin
                register_write_latch_d = 1'b0;
                nbyte_d = 2'h2;
              end else begin
                oe_d = 1'b1;
                awr_v_d = 1'b1;
                awr_d = '{addr: addr_q[ADDR_W-1:0], data: sh_q};
                addr_d = {addr_q[15:PAGE_W],
                          addr_q[PAGE_W-1:0] + PAGE_W'(1)};
                wdata_d = sh_q;
                nbyte_d = 2'h1;
              end
            end
            ST_RD: begin
              sent_d = 1'b1;
              if (!reg_rd_q) begin
                addr_d = {5'h00, addr_q[ADDR_W-1:0] + ADDR_W'(1)};
              end
            end
            default: begin
              st_d = ST_IGN;
            end
          endcase
        end else if (ack_q && cnt_q == ACK_SLOT) begin
          // End of ack slot: release, or start the next read byte
          ack_d = 1'b0;
          cnt_d = 4'h0;
          oe_d = 1'b0;
          if (st_q == ST_RD) begin
            if (reg_rd_q && sent_q) begin
              st_d = ST_IDLE;
            end else if (mnack_q) begin
              st_d = ST_IGN;
            end else begin
              oe_d = ~next_byte[7];
              tx_d = {next_byte[6:0], 1'b0};
            end
          end
        end else if (!ack_q && st_q == ST_RD && cnt_q != 4'h0) begin
          oe_d = ~tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // Bus engine registers; latches clear on reset, reads never touch them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      wdata_q <= 8'h00;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      mnack_q <= 1'b0;
      sent_q <= 1'b0;
      reg_rd_q <= 1'b0;
      nbyte_q <= 2'h0;
      addr_q <= 16'h0000;
      wel_q <= 1'b0;
      register_write_latch_q <= 1'b0;
      busy_q <= '0;
      trip_q <= 1'b0;
      awr_v_q <= 1'b0;
      awr_q <= '0;
      hwp_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      wdata_q <= wdata_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      mnack_q <= mnack_d;
      sent_q <= sent_d;
      reg_rd_q <= reg_rd_d;
      nbyte_q <= nbyte_d;
      addr_q <= addr_d;
      wel_q <= wel_d;
      register_write_latch_q <= register_write_latch_d;
      busy_q <= busy_d;
      trip_q <= trip_d;
      awr_v_q <= awr_v_d;
      awr_q <= awr_d;
      hwp_q <= hwp_d;
      sda_out_q <= 1'b0;
    end
  end

  // Watchdog limit from the period select
  always_comb begin
    case (nv_q.period)
      DOG_LONG: dog_lim = CNT_W'(DOG_LONG_CYC_P - 1);
      DOG_MID: dog_lim = CNT_W'(DOG_MID_CYC_P - 1);
      DOG_SHORT: dog_lim = CNT_W'(DOG_SHORT_CYC_P - 1);
      default: dog_lim = '0;
    endcase
    dog_cnt_d = dog_cnt_q;
    dog_rst_d = dog_rst_q;
    if (nv_q.period == DOG_OFF || start_ev) begin
      dog_cnt_d = '0;
      dog_rst_d = 1'b0;
    end else if (dog_cnt_q >= dog_lim) begin
      dog_rst_d = 1'b1;
    end else begin
      dog_cnt_d = dog_cnt_q + CNT_W'(1);
    end
  end

  // Watchdog registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dog_cnt_q <= '0;
      dog_rst_q <= 1'b0;
    end else begin
      dog_cnt_q <= dog_cnt_d;
      dog_rst_q <= dog_rst_d;
    end
  end

  // Outputs from flops, except nv_busy, which is decoded from busy_q
  assign sda_out = sda_out_q;
  assign sda_oe = oe_q;
  assign array_rd_addr = addr_q[ADDR_W-1:0];
  assign array_wr_valid = awr_v_q;
  assign array_wr = awr_q;
  assign array_lock_sel = nv_q.lock;
  assign dog_period = nv_q.period;
  assign hw_protect = hwp_q;
  assign dog_reset = dog_rst_q;
  assign supply_trip_level = trip_q;
  assign nv_busy = (busy_q != '0);

endmodule // scr_control_regs

// ==== test/scr_control_monitor.sv ====
// Port checker for the supervisor control register.
// Bound into scr_control_regs; sees only that module's ports.
`timescale 1ns/100ps
module scr_control_monitor
  import scr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic protect_pin,
  input wire logic program_voltage,
  input wire logic array_wr_valid,
  input wire scr_wr_type array_wr,
  input wire logic [2:0] array_lock_sel,
  input wire logic [1:0] dog_period,
  input wire logic hw_protect,
  input wire logic dog_reset,
  input wire logic supply_trip_level,
  input wire logic nv_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Outputs quiet once reset has been seen
  a_reset_quiet: assert property (disable iff (1'b0)
    srst |=> !sda_oe && !nv_busy && !array_wr_valid && !dog_reset)
    else $error("output active after reset");
  // Accepted array writes lie outside the locked range
  a_lock_guard: assert property (array_wr_valid |->
    !(array_lock_sel == LOCK_ALL || (array_lock_sel[2] &&
    (array_wr.addr[10:6] >> array_lock_sel[1:0]) == 5'h0)))
    else $error("array write inside locked range");
  a_wr_single: assert property (array_wr_valid |=> !array_wr_valid)
    else $error("array write pulse too long");
  // No answer on the bus while storing
  a_busy_quiet: assert property (nv_busy |-> !sda_oe)
    else $error("ack during store cycle");
  // Stored fields move only with a store cycle
  a_field_hold: assert property (
    $changed({array_lock_sel, dog_period}) |-> ##[0:2] nv_busy)
    else $error("fields changed without store");
  a_dog_off: assert property (
    (dog_period == DOG_OFF) [*2] |-> !dog_reset)
    else $error("watchdog fired while off");
  a_dog_restart: assert property (
    scl_in && $fell(sda_in) |-> ##[1:8] !dog_reset)
    else $error("start did not clear watchdog");
  a_pin_low: assert property (!protect_pin [*8] |-> !hw_protect)
    else $error("protect active with pin low");
  a_trip_end: assert property (
    !program_voltage [*8] |-> !supply_trip_level)
    else $error("trip programming outlived voltage");
endmodule // scr_control_monitor

bind scr_control_regs scr_control_monitor i_mon (.*);

// ==== test/scr_host_model.sv ====
// Two-wire bus master model: drives SCL, pulls SDA low.
// Assumes the bench resolves SDA as an open-drain wire with pull-up.
`timescale 1ns/100ps
module scr_host_model (
  input wire logic ref_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // Bus idle at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Half bus period, and a short hold after SCL falls
  task automatic half();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic gap();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // Start or repeated start; ends with SCL low
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    gap();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // One clock; data only moves while SCL is low
  task automatic clk_bit(input logic b, output logic got);
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    got = sda_in;
    scl = 1'b0;
    gap();
  endtask
  // Byte out MSB first, then the slave's answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], g);
    clk_bit(1'b1, g);
    ack = !g;
  endtask
  // Byte in, answered with no ack
  task automatic get_byte(output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(1'b1, g);
  endtask
endmodule // scr_host_model

// ==== test/supervisor_control_register_bench.sv ====
// Self-checking bench for the supervisor control register.
// Assumes the host model and checker files compile before it.
`timescale 1ns/100ps
module supervisor_control_register_bench import scr_pkg::*;;
  typedef struct packed {
    logic [7:0] data;
    logic ack;
    logic [7:0] rd;
    logic busy;
  } scr_row_type;
  logic ref_clk, srst, scl_in, sda_low, sda_in, sda_out, sda_oe;
  logic protect_pin, program_voltage, array_wr_valid, hw_protect;
  logic dog_reset, supply_trip_level, nv_busy, a, b;
  logic [7:0] array_rd_data, v;
  logic [ADDR_W-1:0] array_rd_addr;
  logic [2:0] array_lock_sel;
  logic [1:0] dog_period;
  scr_wr_type array_wr, wr_last;
  int err_total = 0, n_checks = 0, cyc = 0, wr_n = 0, n0;
  // Write byte, ack, read-back, store busy after stop
  scr_row_type rows [7] = '{'{8'h06, 1'b0, 8'h60, 1'b0},
    '{8'h02, 1'b1, 8'h62, 1'b0}, '{8'h06, 1'b1, 8'h66, 1'b0},
    '{8'h06, 1'b1, 8'h66, 1'b0}, '{8'h2b, 1'b1, 8'h2b, 1'b1},
    '{8'h00, 1'b1, 8'h29, 1'b0}, '{8'h2b, 1'b0, 8'h29, 1'b0}};

  // Open-drain SDA with pull-up; memory answers with its address
  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  assign array_rd_data = array_rd_addr[7:0];

  scr_control_regs #(.DOG_LONG_CYC_P(4000), .DOG_MID_CYC_P(3000),
    .DOG_SHORT_CYC_P(2000), .NV_CYCLE_CYC_P(50)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .protect_pin(protect_pin),
    .program_voltage(program_voltage), .array_rd_data(array_rd_data),
    .array_rd_addr(array_rd_addr), .array_wr_valid(array_wr_valid),
    .array_wr(array_wr), .array_lock_sel(array_lock_sel),
    .dog_period(dog_period), .hw_protect(hw_protect),
    .dog_reset(dog_reset), .supply_trip_level(supply_trip_level),
    .nv_busy(nv_busy));
  scr_host_model i_host (.ref_clk(ref_clk), .sda_in(sda_in),
    .scl(scl_in), .sda_low(sda_low));

  // Clock at 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = !ref_clk;
  end
  // Array write capture and run ceiling, tests need about 34k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (array_wr_valid === 1'b1) begin
      wr_last = array_wr;
      wr_n++;
    end
    if (cyc == 100000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("Test %s done", s);
  endtask
  // Byte write at a two-byte address, own start and stop
  task automatic wr(input logic [15:0] ad, input logic [7:0] d,
                    output logic ack);
    logic k;
    i_host.start();
    i_host.put_byte({DEV_ADDR, 1'b0}, k);
    i_host.put_byte(ad[15:8], k);
    i_host.put_byte(ad[7:0], k);
    i_host.put_byte(d, ack);
    i_host.stop();
  endtask
  // Random read of the control register
  task automatic rd(output logic [7:0] d);
    logic k;
    i_host.start();
    i_host.put_byte({DEV_ADDR, 1'b0}, k);
    i_host.put_byte(8'hff, k);
    i_host.put_byte(8'hff, k);
    i_host.start();
    i_host.put_byte({DEV_ADDR, 1'b1}, k);
    i_host.get_byte(d);
    i_host.stop();
  endtask
  task automatic seq3(input logic [7:0] d);
    logic k;
    wr(REG_ADDR, SET_WL, k);
    wr(REG_ADDR, SET_BOTH, k);
    wr(REG_ADDR, d, k);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    protect_pin = 1'b0;
    program_voltage = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    repeat (6) @(posedge ref_clk);
    foreach (rows[i]) begin
      wr(REG_ADDR, rows[i].data, a);
      chk(a, rows[i].ack);
      chk(nv_busy, rows[i].busy);
      rd(v);
      chk(v, rows[i].rd);
    end
    chk({array_lock_sel, dog_period}, 5'h15);
    done("table");
    // Two data bytes in one register write
    i_host.start();
    i_host.put_byte({DEV_ADDR, 1'b0}, a);
    i_host.put_byte(8'hff, a);
    i_host.put_byte(8'hff, a);
    i_host.put_byte(SET_WL, a);
    i_host.put_byte(SET_WL, b);
    i_host.stop();
    chk({a, b}, 2'h2);
    rd(v);
    chk(v, 8'h29);
    done("second byte");
    // Locked and open array pages
    wr(REG_ADDR, SET_WL, a);
    wr(REG_ADDR, SET_BOTH, a);
    n0 = wr_n;
    wr(16'h0040, 8'h5a, a);
    chk({a, wr_n - n0 == 0}, 2'h1);
    rd(v);
    chk(v, 8'h2b);
    wr(16'h0080, 8'h5a, a);
    chk({a, wr_n - n0 == 1}, 2'h3);
    chk(wr_last, {11'h080, 8'h5a});
    done("lock");
    // Trip programming with the programming voltage
    program_voltage = 1'b1;
    wr(16'h0100, TRIP_DATA, a);
    chk(supply_trip_level, 1'b1);
    program_voltage = 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(supply_trip_level, 1'b0);
    done("trip");
    // Watchdog expiry at the middle period, cleared by a start
    repeat (3100) @(posedge ref_clk);
    chk(dog_reset, 1'b1);
    i_host.start();
    i_host.stop();
    chk(dog_reset, 1'b0);
    done("watchdog");
    // Pin high: arm writable while clear, then frozen
    protect_pin = 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(hw_protect, 1'b0);
    seq3(8'hab);
    chk(hw_protect, 1'b1);
    seq3(8'h2a);
    rd(v);
    chk(v, 8'hab);
    done("protect");
    // Mid-run reset keeps stored fields, clears latches
    protect_pin = 1'b0;
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({array_lock_sel, dog_period}, 5'h15);
    rd(v);
    chk(v, 8'ha9);
    done("reset");
    report_and_stop();
  end
endmodule // supervisor_control_register_bench
